// file: hw/led_dimming_nvm_config_regs.v
// Non-volatile LED configuration registers with deadband and slope logic.
`timescale 1ns/1ps
`include "nvm_cfg_consts.vh"
module led_dimming_nvm_config_regs #(
  parameter        CYCLES_PER_MS = `CLK_MHZ * 1000,  // Clock cycles per millisecond.
  parameter [7:0]  NVM_INIT0     = 8'h00,            // Stored default of word 0.
  parameter [7:0]  NVM_INIT1     = 8'h00,            // Stored default of word 1.
  parameter [7:0]  NVM_INIT2     = 8'h00             // Stored default of word 2.
) (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        arst_n,
  // Host register port.
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  // Fields held in other registers.
  input  wire [2:0]  full_scale_select,
  input  wire [2:0]  pattern_a,
  // Measured PWM input duty.
  input  wire [15:0] pwm_duty_in,
  input  wire        pwm_duty_valid,
  // Decoded sink settings.
  output reg  [3:0]  knee_ua,
  output reg  [10:0] bias_ua,
  output reg  [9:0]  rise_ns,
  output reg  [17:0] sink_current_ua,
  output wire [11:0] sink_current_code,
  // Dimming controls.
  output reg         pattern_a_active,
  output reg  [2:0]  pattern_a_pattern,
  output reg  [15:0] duty_accepted,
  output reg  [15:0] brightness,
  output reg         ramping,
  // Storage status.
  output reg         nvm_idle_flag,
  output wire        cfg_unlocked
);

  // One-hot states of the unlock tracker.
  localparam [3:0] LK_LOCKED = 4'b0001;
  localparam [3:0] LK_KEY1   = 4'b0010;
  localparam [3:0] LK_KEY2   = 4'b0100;
  localparam [3:0] LK_OPEN   = 4'b1000;
  // One-hot states of the storage sequencer.
  localparam [2:0] NV_IDLE   = 3'b001;
  localparam [2:0] NV_READ   = 3'b010;
  localparam [2:0] NV_PROG   = 3'b100;

  reg  [7:0]  cfg0_reg;       // Knee, bias and upper current code.
  reg  [7:0]  cfg1_reg;       // Lower current code.
  reg  [7:0]  cfg2_reg;       // Pattern_a, deadband and slope fields.
  reg  [1:0]  ctrl_cmd_reg;   // Stored program and reload bits.
  reg  [3:0]  lock_reg;       // Unlock tracker state.
  reg  [2:0]  nv_state_reg;   // Storage sequencer state.
  reg  [1:0]  nv_idx_reg;     // Word being issued.
  reg         cap_vld_reg;    // Read data due this cycle.
  reg  [1:0]  cap_idx_reg;    // Word that the read data belongs to.
  reg  [15:0] target_reg;     // Brightness the ramp heads for.
  reg  [15:0] span_reg;       // Size of the current transition.
  reg  [15:0] moved_reg;      // Steps taken in this transition.
  reg  [31:0] acc_reg;        // Slope accumulator.
  reg  [1:0]  mem_addr;       // Storage address.
  reg         mem_rd;         // Storage read strobe.
  reg         mem_wr;         // Storage write strobe.
  reg  [7:0]  mem_wdata;      // Storage write data.
  wire [7:0]  mem_rdata;      // Storage read data.

  // Field views of the configuration registers.
  wire [1:0]  knee_sel   = cfg0_reg[`KNEE_HI:`KNEE_LO];
  wire [1:0]  bias_sel   = cfg0_reg[`BIAS_HI:`BIAS_LO];
  wire        steady_on  = cfg2_reg[`PATTERN_A_BIT];
  wire [1:0]  db_sel     = cfg2_reg[`DEADBAND_HI:`DEADBAND_LO];
  wire        smooth_on  = cfg2_reg[`SMOOTH_BIT];
  wire [2:0]  slope_sel  = cfg2_reg[`SLOPE_HI:`SLOPE_LO];
  wire        nv_busy    = !nv_state_reg[0];
  wire        cfg_wr_ok  = lock_reg[3] && !nv_busy;

  // The upper four bits and the lower byte join into the twelve-bit code.
  assign sink_current_code = {cfg0_reg[`CODE_HI_HI:`CODE_HI_LO], cfg1_reg};
  assign cfg_unlocked      = lock_reg[3];

  // Distance between two duty values, used by deadband and ramp.
  function [15:0] abs_diff;
    input [15:0] a;
    input [15:0] b;
    begin
      abs_diff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // Full scale current in microamps for a scale select code.
  function [17:0] fs_ua;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    fs_ua = 18'd25000;
        3'h1:    fs_ua = 18'd30000;
        3'h2:    fs_ua = 18'd50000;
        3'h3:    fs_ua = 18'd60000;
        3'h4:    fs_ua = 18'd80000;
        3'h5:    fs_ua = 18'd100000;
        3'h6:    fs_ua = 18'd120000;
        default: fs_ua = 18'd150000;
      endcase
    end
  endfunction

  // Deadband width in steps for the deadband code.
  reg [15:0] db_step;
  always @* begin
    case (db_sel)
      2'h0:    db_step = `DB_STEP_0;
      2'h1:    db_step = `DB_STEP_1;
      2'h2:    db_step = `DB_STEP_2;
      default: db_step = `DB_STEP_3;
    endcase
  end

  // Cycles needed for a whole linear transition at the chosen time.
  reg [31:0] slope_cycles;
  always @* begin
    case (slope_sel)
      3'h1:    slope_cycles = `SLOPE_MS_1 * CYCLES_PER_MS;
      3'h2:    slope_cycles = `SLOPE_MS_2 * CYCLES_PER_MS;
      3'h3:    slope_cycles = `SLOPE_MS_3 * CYCLES_PER_MS;
      3'h4:    slope_cycles = `SLOPE_MS_4 * CYCLES_PER_MS;
      3'h5:    slope_cycles = `SLOPE_MS_5 * CYCLES_PER_MS;
      3'h6:    slope_cycles = `SLOPE_MS_6 * CYCLES_PER_MS;
      3'h7:    slope_cycles = `SLOPE_MS_7 * CYCLES_PER_MS;
      default: slope_cycles = 32'h0000_0001;
    endcase
  end

  // The unlock tracker follows key writes; any other value relocks.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_reg <= LK_LOCKED;
    end else if (reg_wr && reg_addr == `ADDR_UNLOCK) begin
      case (lock_reg)
        LK_LOCKED: lock_reg <= (reg_wdata == `UNLOCK_KEY0) ? LK_KEY1 : LK_LOCKED;
        LK_KEY1:   lock_reg <= (reg_wdata == `UNLOCK_KEY1) ? LK_KEY2 : LK_LOCKED;
        LK_KEY2:   lock_reg <= (reg_wdata == `UNLOCK_KEY2) ? LK_OPEN : LK_LOCKED;
        default:   lock_reg <= (reg_wdata == `UNLOCK_KEY0) ? LK_KEY1 : LK_LOCKED;
      endcase
    end
  end

  // Host writes, reload capture and the storage sequencer.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg0_reg      <= `CFG_RESET;
      cfg1_reg      <= `CFG_RESET;
      cfg2_reg      <= `CFG_RESET;
      ctrl_cmd_reg  <= 2'h0;
      nv_state_reg  <= NV_READ;
      nv_idx_reg    <= 2'h0;
      cap_vld_reg   <= 1'b0;
      cap_idx_reg   <= 2'h0;
      mem_addr      <= 2'h0;
      mem_rd        <= 1'b0;
      mem_wr        <= 1'b0;
      mem_wdata     <= 8'h00;
      nvm_idle_flag <= 1'b0;
    end else begin
      mem_rd      <= 1'b0;
      mem_wr      <= 1'b0;
      cap_vld_reg <= mem_rd;
      cap_idx_reg <= mem_addr;
      // Locked or busy configuration registers ignore host writes.
      if (reg_wr && cfg_wr_ok) begin
        if (reg_addr == `ADDR_CFG0) cfg0_reg <= reg_wdata;
        if (reg_addr == `ADDR_CFG1) cfg1_reg <= reg_wdata;
        if (reg_addr == `ADDR_CFG2) cfg2_reg <= reg_wdata & `CFG2_RW_MASK;
      end
      if (reg_wr && lock_reg[3] && reg_addr == `ADDR_NVM_CTRL) begin
        ctrl_cmd_reg <= {reg_wdata[`CTRL_PROG_BIT], reg_wdata[`CTRL_READ_BIT]};
      end
      // Reloaded words overwrite the registers as they arrive.
      if (cap_vld_reg) begin
        case (cap_idx_reg)
          2'h0:    cfg0_reg <= mem_rdata;
          2'h1:    cfg1_reg <= mem_rdata;
          default: cfg2_reg <= mem_rdata & `CFG2_RW_MASK;
        endcase
      end
      case (nv_state_reg)
        NV_IDLE: begin
          nvm_idle_flag <= 1'b1;
          nv_idx_reg    <= 2'h0;
          if (reg_wr && lock_reg[3] && reg_addr == `ADDR_NVM_CTRL) begin
            if (reg_wdata[`CTRL_READ_BIT] && !ctrl_cmd_reg[0]) begin
              nv_state_reg  <= NV_READ;
              nvm_idle_flag <= 1'b0;
            end else if (reg_wdata[`CTRL_PROG_BIT] && !ctrl_cmd_reg[1]) begin
              nv_state_reg  <= NV_PROG;
              nvm_idle_flag <= 1'b0;
            end
          end
        end
        NV_READ: begin
          nvm_idle_flag <= 1'b0;
          if (nv_idx_reg != 2'h3) begin
            mem_rd     <= 1'b1;
            mem_addr   <= nv_idx_reg;
            nv_idx_reg <= nv_idx_reg + 2'h1;
          end else if (!mem_rd && !cap_vld_reg) begin
            nv_state_reg  <= NV_IDLE;
            nvm_idle_flag <= 1'b1;
          end
        end
        NV_PROG: begin
          nvm_idle_flag <= 1'b0;
          if (nv_idx_reg != 2'h3) begin
            mem_wr     <= 1'b1;
            mem_addr   <= nv_idx_reg;
            mem_wdata  <= (nv_idx_reg == 2'h0) ? cfg0_reg :
                          (nv_idx_reg == 2'h1) ? cfg1_reg : cfg2_reg;
            nv_idx_reg <= nv_idx_reg + 2'h1;
          end else begin
            nv_state_reg  <= NV_IDLE;
            nvm_idle_flag <= 1'b1;
          end
        end
        default: nv_state_reg <= NV_IDLE;
      endcase
    end
  end

  // Register reads answer one cycle after the strobe.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_CFG0:     reg_rdata <= cfg0_reg;
          `ADDR_CFG1:     reg_rdata <= cfg1_reg;
          `ADDR_CFG2:     reg_rdata <= cfg2_reg;
          `ADDR_NVM_CTRL: reg_rdata <= {!nv_busy, 5'h00, ctrl_cmd_reg};
          default:        reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Code times full scale over the full code; the quotient never exceeds 18 bits.
  wire [31:0] cur_prod = {20'h00000, sink_current_code} * {14'h0, fs_ua(full_scale_select)};
  wire [31:0] cur_quot = cur_prod / `CODE_FULL;

  // Decoded sink settings, registered for the analog side.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      knee_ua         <= 4'h1;
      bias_ua         <= 11'd200;
      rise_ns         <= 10'd800;
      sink_current_ua <= 18'h00000;
    end else begin
      knee_ua <= {knee_sel, 2'h0} + 4'h1;
      case (bias_sel)
        2'h0:    begin bias_ua <= 11'd200;  rise_ns <= 10'd800; end
        2'h1:    begin bias_ua <= 11'd400;  rise_ns <= 10'd400; end
        2'h2:    begin bias_ua <= 11'd800;  rise_ns <= 10'd200; end
        default: begin bias_ua <= 11'd1600; rise_ns <= 10'd100; end
      endcase
      sink_current_ua <= cur_quot[17:0];
    end
  end

  // Eased slope moves at half rate near the ends, faster in the middle.
  wire [15:0] quarter   = {2'h0, span_reg[15:2]};
  wire        outer     = (moved_reg < quarter) || (moved_reg >= span_reg - quarter);
  wire [31:0] slope_inc = !smooth_on ? {16'h0000, span_reg} :
                          outer ? {17'h00000, span_reg[15:1]} :
                          {16'h0000, span_reg} + {17'h00000, span_reg[15:1]};
  wire [31:0] acc_sum   = acc_reg + slope_inc;
  wire        adopt     = pwm_duty_valid &&
                          (abs_diff(pwm_duty_in, duty_accepted) > db_step);

  // Deadband on the input duty and the brightness ramp.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      duty_accepted <= 16'h0000;
      target_reg    <= 16'h0000;
      span_reg      <= 16'h0000;
      moved_reg     <= 16'h0000;
      acc_reg       <= 32'h0000_0000;
      brightness    <= 16'h0000;
      ramping       <= 1'b0;
    end else if (adopt) begin
      duty_accepted <= pwm_duty_in;
      target_reg    <= pwm_duty_in;
      span_reg      <= abs_diff(pwm_duty_in, brightness);
      moved_reg     <= 16'h0000;
      acc_reg       <= 32'h0000_0000;
      if (slope_sel == 3'h0) begin
        brightness <= pwm_duty_in;
        ramping    <= 1'b0;
      end else begin
        ramping    <= (pwm_duty_in != brightness);
      end
    end else if (brightness != target_reg) begin
      ramping <= 1'b1;
      if (slope_sel == 3'h0) begin
        brightness <= target_reg;
      end else if (acc_sum >= slope_cycles) begin
        acc_reg    <= acc_sum - slope_cycles;
        moved_reg  <= moved_reg + 16'h0001;
        brightness <= (target_reg > brightness) ? brightness + 16'h0001
                                                : brightness - 16'h0001;
      end else begin
        acc_reg <= acc_sum;
      end
    end else begin
      ramping <= 1'b0;
    end
  end

  // Pattern_a runs while ramping, and always when steady pattern_a is on.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_a_active  <= 1'b0;
      pattern_a_pattern <= 3'h0;
    end else begin
      pattern_a_active  <= steady_on || ramping;
      pattern_a_pattern <= (steady_on || ramping) ? pattern_a : 3'h0;
    end
  end

  // Non-volatile copy of the three registers.
  nvm_store #(
    .INIT0 (NVM_INIT0),
    .INIT1 (NVM_INIT1),
    .INIT2 (NVM_INIT2)
  ) u_store (
    .core_clk  (core_clk),
    .arst_n    (arst_n),
    .mem_addr  (mem_addr),
    .mem_rd    (mem_rd),
    .mem_wr    (mem_wr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata)
  );

endmodule

// file: hw/nvm_cfg_consts.vh
// Constants for the non-volatile LED configuration register bank.
`ifndef NVM_CFG_CONSTS_VH
`define NVM_CFG_CONSTS_VH

// Register addresses on the host register port.
`define ADDR_CFG0          8'h60
`define ADDR_CFG1          8'h61
`define ADDR_CFG2          8'h62
`define ADDR_NVM_CTRL      8'h19
`define ADDR_UNLOCK        8'h1a

// Unlock key sequence written to the unlock register.
`define UNLOCK_KEY0        8'h08
`define UNLOCK_KEY1        8'hba
`define UNLOCK_KEY2        8'hef

// Field positions in the first configuration register.
`define KNEE_HI            7
`define KNEE_LO            6
`define BIAS_HI            5
`define BIAS_LO            4
`define CODE_HI_HI         3
`define CODE_HI_LO         0

// Field positions in the third configuration register.
`define PATTERN_A_BIT         6
`define DEADBAND_HI        5
`define DEADBAND_LO        4
`define SMOOTH_BIT         3
`define SLOPE_HI           2
`define SLOPE_LO           0
`define CFG2_RW_MASK       8'h7f

// Field positions in the storage control register.
`define CTRL_IDLE_BIT      7
`define CTRL_PROG_BIT      1
`define CTRL_READ_BIT      0

// Reset values.
`define CTRL_RESET         8'h80
`define CFG_RESET          8'h00

// Current code full scale divisor.
`define CODE_FULL          4095

// Clock rate and linear slope times in milliseconds.
`define CLK_MHZ            125
`define SLOPE_MS_1         1
`define SLOPE_MS_2         2
`define SLOPE_MS_3         52
`define SLOPE_MS_4         105
`define SLOPE_MS_5         210
`define SLOPE_MS_6         315
`define SLOPE_MS_7         511

// Deadband step counts at 16-bit resolution.
`define DB_STEP_0          16'h0001
`define DB_STEP_1          16'h0008
`define DB_STEP_2          16'h0010
`define DB_STEP_3          16'h0100

`endif

// file: hw/nvm_store.v
// Small non-volatile word store with registered read data.
`timescale 1ns/1ps
module nvm_store #(
  parameter [7:0] INIT0 = 8'h00,  // Programmed default of word 0.
  parameter [7:0] INIT1 = 8'h00,  // Programmed default of word 1.
  parameter [7:0] INIT2 = 8'h00   // Programmed default of word 2.
) (
  // Clock and reset.
  input  wire       core_clk,
  input  wire       arst_n,
  // Access port.
  input  wire [1:0] mem_addr,
  input  wire       mem_rd,
  input  wire       mem_wr,
  input  wire [7:0] mem_wdata,
  output reg  [7:0] mem_rdata
);

  reg [7:0] word0_reg;  // Stored word 0.
  reg [7:0] word1_reg;  // Stored word 1.
  reg [7:0] word2_reg;  // Stored word 2.

  // Writes store a word; reads return it one cycle later.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      word0_reg <= INIT0;
      word1_reg <= INIT1;
      word2_reg <= INIT2;
      mem_rdata <= 8'h00;
    end else begin
      if (mem_wr && mem_addr == 2'h0) word0_reg <= mem_wdata;
      if (mem_wr && mem_addr == 2'h1) word1_reg <= mem_wdata;
      if (mem_wr && mem_addr == 2'h2) word2_reg <= mem_wdata;
      if (mem_rd) begin
        case (mem_addr)
          2'h0:    mem_rdata <= word0_reg;
          2'h1:    mem_rdata <= word1_reg;
          2'h2:    mem_rdata <= word2_reg;
          default: mem_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// file: tb/led_cfg_checker.sv
// Port-level assertions for the LED configuration register bank.
`timescale 1ns/1ps
module led_cfg_checker (
  // Clock and reset.
  input wire        core_clk,
  input wire        arst_n,
  // Host register port.
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        reg_rvalid,
  // Duty input and scale select.
  input wire [2:0]  full_scale_select,
  input wire [15:0] pwm_duty_in,
  input wire        pwm_duty_valid,
  // Decoded outputs and status.
  input wire [3:0]  knee_ua,
  input wire [10:0] bias_ua,
  input wire [9:0]  rise_ns,
  input wire [17:0] sink_current_ua,
  input wire [11:0] sink_current_code,
  input wire        pattern_a_active,
  input wire [15:0] duty_accepted,
  input wire [15:0] brightness,
  input wire        ramping,
  input wire        nvm_idle_flag,
  input wire        cfg_unlocked
);
  // Distance between a new duty sample and the accepted duty.
  wire [15:0] gap;
  assign gap = (pwm_duty_in > duty_accepted) ? pwm_duty_in - duty_accepted
                                             : duty_accepted - pwm_duty_in;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Read data of the first register matches the decoded knee and bias.
  knee_bias_a: assert property (
    reg_rvalid && $past(reg_rd) && $past(reg_addr) == 8'h60 && nvm_idle_flag &&
    $past(nvm_idle_flag, 2) |-> knee_ua == {reg_rdata[7:6], 2'b01} &&
    bias_ua == (11'd200 << reg_rdata[5:4])) else $error("knee or bias decode wrong");
  // Faster edges always come with the matching higher bias.
  rise_bias_a: assert property (
    {22'd0, rise_ns} * bias_ua == 32'd160000) else $error("rise time and bias disagree");
  full_scale_a: assert property (
    (sink_current_code == 12'hfff && full_scale_select == 3'h7) [*3]
    |-> sink_current_ua == 18'd150000) else $error("full code not full scale");
  zero_code_a: assert property (
    sink_current_code == 12'h000 [*3] |-> sink_current_ua == 18'd0)
    else $error("zero code gives current");
  small_change_a: assert property (
    pwm_duty_valid && gap <= 16'd1 |=> $stable(duty_accepted))
    else $error("duty change inside deadband adopted");
  big_change_a: assert property (
    pwm_duty_valid && gap > 16'h0100 |=> duty_accepted == $past(pwm_duty_in))
    else $error("large duty change not adopted");
  ramp_end_a: assert property (
    $fell(ramping) |-> brightness == duty_accepted) else $error("ramp ended off target");
  ramp_pattern_a_a: assert property (
    ramping [*2] |-> pattern_a_active) else $error("no pattern_a while ramping");
  unlock_drop_a: assert property (
    reg_wr && reg_addr == 8'h1a && !(reg_wdata inside {8'h08, 8'hba, 8'hef})
    |=> !cfg_unlocked) else $error("foreign code left bank unlocked");
  busy_bound_a: assert property (
    $fell(nvm_idle_flag) |-> ##[1:40] nvm_idle_flag) else $error("reload never finished");
  // Main scenarios reached.
  cover property ($rose(ramping));
  cover property ($rose(cfg_unlocked));
  cover property ($fell(nvm_idle_flag));
endmodule

// file: tb/led_dimming_nvm_config_regs_tb.sv
// Self-checking testbench for the LED configuration register bank.
`timescale 1ns/1ps
`include "nvm_cfg_consts.vh"
module led_dimming_nvm_config_regs_tb;
  localparam CPM = 200;  // Shortened millisecond so ramps stay brief.
  reg         core_clk = 1'b0;
  reg         arst_n = 1'b0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [2:0]  full_scale_select = 3'h7;
  reg  [2:0]  pattern_a = 3'h5;
  reg  [15:0] pwm_duty_in = 16'h0000;
  reg         pwm_duty_valid = 1'b0;
  wire [7:0]  reg_rdata;
  wire        reg_rvalid;
  wire [3:0]  knee_ua;
  wire [10:0] bias_ua;
  wire [9:0]  rise_ns;
  wire [17:0] sink_current_ua;
  wire [11:0] sink_current_code;
  wire        pattern_a_active;
  wire [2:0]  pattern_a_pattern;
  wire [15:0] duty_accepted;
  wire [15:0] brightness;
  wire        ramping;
  wire        nvm_idle_flag;
  wire        cfg_unlocked;
  integer     err_count = 0;
  integer     comparisons = 0;
  reg  [15:0] base;  // Duty value the bench expects to be accepted.
  led_dimming_nvm_config_regs #(.CYCLES_PER_MS(CPM), .NVM_INIT0(8'h5a),
    .NVM_INIT1(8'h3c), .NVM_INIT2(8'h11)) led_dimming_nvm_config_regs_inst (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .full_scale_select(full_scale_select), .pattern_a(pattern_a),
    .pwm_duty_in(pwm_duty_in), .pwm_duty_valid(pwm_duty_valid), .knee_ua(knee_ua),
    .bias_ua(bias_ua), .rise_ns(rise_ns), .sink_current_ua(sink_current_ua),
    .sink_current_code(sink_current_code), .pattern_a_active(pattern_a_active),
    .pattern_a_pattern(pattern_a_pattern), .duty_accepted(duty_accepted),
    .brightness(brightness), .ramping(ramping), .nvm_idle_flag(nvm_idle_flag),
    .cfg_unlocked(cfg_unlocked));
  // Free-running 125 MHz clock.
  always #4 core_clk = ~core_clk;
  // Compares one result and counts it.
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Lets n edges pass and lands just after the last one.
  task cyc(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task finish_test;
    begin
      $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Waits for idle (sel high) or for the ramp to end (sel low), bounded.
  task wait_on(input sel, input integer lim, output integer n);
    begin
      n = 0;
      while ((sel ? nvm_idle_flag !== 1'b1 : ramping !== 1'b0) && n < lim) begin
        cyc(1);
        n = n + 1;
      end
      if (n >= lim) begin
        chk(32'h0, 32'h1);
        finish_test;
      end
    end
  endtask
  // One register write, strobe held for one edge.
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      cyc(1);
      reg_wr = 1'b0;
      cyc(1);
    end
  endtask
  // One register read; the answer comes one edge after the strobe.
  task rd(input [7:0] a, input [7:0] exp);
    begin
      reg_addr = a;
      reg_rd = 1'b1;
      cyc(1);
      reg_rd = 1'b0;
      chk(reg_rvalid, 1'b1);
      chk(reg_rdata, exp);
      cyc(1);
    end
  endtask
  // Offers one duty sample and checks the accepted value.
  task duty(input [15:0] v, input [15:0] exp);
    begin
      pwm_duty_in = v;
      pwm_duty_valid = 1'b1;
      cyc(1);
      pwm_duty_valid = 1'b0;
      cyc(3);
      chk(duty_accepted, exp);
    end
  endtask
  // Stored defaults appear after the automatic reload.
  task t_boot;
    integer n;
    begin
      wait_on(1'b1, 100, n);
      rd(`ADDR_CFG0, 8'h5a);
      rd(`ADDR_CFG1, 8'h3c);
      rd(`ADDR_CFG2, 8'h11);
      rd(`ADDR_NVM_CTRL, `CTRL_RESET);
      rd(`ADDR_UNLOCK, 8'h00);
      rd(8'h00, 8'h00);
    end
  endtask
  // Writes are refused until the full key, even with writes in between.
  task t_lock;
    begin
      wr(`ADDR_CFG0, 8'hff);
      rd(`ADDR_CFG0, 8'h5a);
      wr(`ADDR_UNLOCK, `UNLOCK_KEY0);
      wr(`ADDR_UNLOCK, `UNLOCK_KEY1);
      wr(`ADDR_CFG1, 8'hc3);
      rd(`ADDR_CFG1, 8'h3c);
      chk(cfg_unlocked, 1'b0);
      wr(`ADDR_UNLOCK, `UNLOCK_KEY2);
      chk(cfg_unlocked, 1'b1);
    end
  endtask
  // Every knee and bias code decodes to its current and rise time.
  task t_fields;
    integer c;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        wr(`ADDR_CFG0, {c[1:0], c[1:0], 4'hf});
        cyc(2);
        chk(knee_ua, 4 * c + 1);
        chk(bias_ua, 200 << c);
        chk(rise_ns, 800 >> c);
      end
    end
  endtask
  // Current code split, linear scaling and full-scale select.
  task t_current;
    begin
      wr(`ADDR_CFG0, 8'h0f);
      wr(`ADDR_CFG1, 8'hff);
      cyc(3);
      chk(sink_current_code, 12'hfff);
      chk(sink_current_ua, 150000);
      full_scale_select = 3'h0;
      cyc(3);
      chk(sink_current_ua, 25000);
      wr(`ADDR_CFG0, 8'h00);
      wr(`ADDR_CFG1, 8'h01);
      cyc(3);
      chk(sink_current_ua, 25000 / `CODE_FULL);
      wr(`ADDR_CFG1, 8'h00);
      cyc(4);
      chk(sink_current_ua, 0);
      full_scale_select = 3'h7;
      wr(`ADDR_CFG2, 8'hff);
      rd(`ADDR_CFG2, `CFG2_RW_MASK);
    end
  endtask
  // Each deadband code: a change equal to the step is ignored, one more is taken.
  task t_deadband;
    reg [15:0] s;
    integer c;
    begin
      base = 16'd1000;
      wr(`ADDR_CFG2, 8'h00);
      duty(base, base);
      chk(brightness, base);
      for (c = 0; c < 4; c = c + 1) begin
        s = (c == 0) ? `DB_STEP_0 : (c == 1) ? `DB_STEP_1 : (c == 2) ? `DB_STEP_2 : `DB_STEP_3;
        wr(`ADDR_CFG2, {2'b00, c[1:0], 4'h0});
        duty(base + s, base);
        base = base + s + 16'd1;
        duty(base, base);
      end
    end
  endtask
  // Ramps of 1, 2 and 52 ms, with the smooth and steady-pattern_a bits varied.
  task t_ramp;
    integer c;
    integer n;
    integer ms;
    begin
      for (c = 1; c < 4; c = c + 1) begin
        ms = (c == 1) ? `SLOPE_MS_1 : (c == 2) ? `SLOPE_MS_2 : `SLOPE_MS_3;
        wr(`ADDR_CFG2, {1'b0, c[0], 2'b00, c[1], c[2:0]});
        base = base + 16'd100;
        duty(base, base);
        chk(ramping, 1'b1);
        chk(pattern_a_active, 1'b1);
        wait_on(1'b0, ms * CPM * 3, n);
        chk(brightness, base);
        chk(c[1] ? (n > ms * CPM * 9 / 8 && n < ms * CPM * 3 / 2)
                 : (n > ms * CPM * 7 / 8 && n < ms * CPM * 9 / 8), 1'b1);
        cyc(2);
        chk(pattern_a_active, c[0]);
        chk(pattern_a_pattern, c[0] ? 3'h5 : 3'h0);
      end
    end
  endtask
  // Relock refuses writes; a reload restores the stored defaults.
  task t_reload;
    integer n;
    begin
      wr(`ADDR_UNLOCK, 8'h00);
      chk(cfg_unlocked, 1'b0);
      wr(`ADDR_CFG0, 8'h33);
      rd(`ADDR_CFG0, 8'h00);
      wr(`ADDR_UNLOCK, `UNLOCK_KEY0);
      wr(`ADDR_UNLOCK, `UNLOCK_KEY1);
      wr(`ADDR_UNLOCK, `UNLOCK_KEY2);
      wr(`ADDR_NVM_CTRL, 8'h01);
      chk(nvm_idle_flag, 1'b0);
      rd(`ADDR_NVM_CTRL, 8'h01);
      wait_on(1'b1, 100, n);
      rd(`ADDR_CFG0, 8'h5a);
      rd(`ADDR_CFG1, 8'h3c);
      rd(`ADDR_CFG2, 8'h11);
      wr(`ADDR_NVM_CTRL, 8'h00);
      // Program a new word 0, scribble over it, then reload it back.
      wr(`ADDR_CFG0, 8'ha5);
      wr(`ADDR_NVM_CTRL, 8'h02);
      wait_on(1'b1, 100, n);
      wr(`ADDR_NVM_CTRL, 8'h00);
      wr(`ADDR_CFG0, 8'h00);
      wr(`ADDR_NVM_CTRL, 8'h01);
      wait_on(1'b1, 100, n);
      rd(`ADDR_CFG0, 8'ha5);
    end
  endtask
  // Main sequence: reset for 8 cycles, then the scenarios.
  initial begin
    cyc(8);
    arst_n = 1'b1;
    t_boot;
    t_lock;
    t_fields;
    t_current;
    t_deadband;
    t_ramp;
    t_reload;
    finish_test;
  end
endmodule
bind led_dimming_nvm_config_regs led_cfg_checker led_cfg_checker_inst (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .full_scale_select(full_scale_select), .pwm_duty_in(pwm_duty_in),
  .pwm_duty_valid(pwm_duty_valid), .knee_ua(knee_ua), .bias_ua(bias_ua),
  .rise_ns(rise_ns), .sink_current_ua(sink_current_ua),
  .sink_current_code(sink_current_code), .pattern_a_active(pattern_a_active),
  .duty_accepted(duty_accepted), .brightness(brightness), .ramping(ramping),
  .nvm_idle_flag(nvm_idle_flag), .cfg_unlocked(cfg_unlocked));
